/* include/pinmux_defines.svh */
// Offsets, bit positions and reset values of the port pin multiplexer
`ifndef PINMUX_DEFINES_SVH
`define PINMUX_DEFINES_SVH

// ==========================================
// Register byte offsets
`define OFS_MCU_CONTROL   8'h00
`define OFS_PA_DIR        8'h04
`define OFS_PA_LATCH      8'h08
`define OFS_PA_PIN        8'h0C
`define OFS_PB_DIR        8'h10
`define OFS_PB_LATCH      8'h14
`define OFS_PB_PIN        8'h18
`define OFS_EMI_CTRL      8'h1C

// ==========================================
// mcu_control fields
`define MCU_DEBUG_DIS     7
`define MCU_PUD           4
`define MCU_VEC_SEL       1
`define MCU_VEC_CHG       0
`define MCU_RESET         8'h00
`define MCU_WR_MASK       8'h93

// ==========================================
// Other fields and resets
`define EMI_ENABLE_BIT    0
`define PORT_RESET        8'h00
`define PIN_SPI_SS        0
`define PIN_SPI_SCK       1
`define PIN_SPI_MOSI      2
`define PIN_SPI_MISO      3
`define PIN_B7            7

`endif

/* include/pinmux_pkg.sv */
// Types shared by the port pin multiplexer
package pinmux_pkg;

  typedef logic [7:0] port_byte_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
  } pad_ctl_t;

endpackage

/* logic/pin_sync.sv */
// Two-stage synchroniser for a bank of pad inputs
`timescale 1ns/100ps
`include "pinmux_defines.svh"
module pin_sync
  import pinmux_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pads
  input  wire port_byte_t pad_in,
  output port_byte_t      sync_out
);

  port_byte_t meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= `PORT_RESET;
      sync_out <= `PORT_RESET;
    end else begin
      meta_r   <= pad_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync

/* logic/port_ab_mux.sv */
// Port A / Port B alternate function pin multiplexer with APB registers
//
// How it works
// - pull_up_disable forces every port pull-up off
// - mcu_control resets zero, bits 7,4,1,0 writable
// - Port A pin n is address/data bit n
// - ext_mem_enable overrides Port A pull, drive, value
// - Port A drives during store or address phase
// - Port A drives address, then store data
// - Port A pull-up only idle, latch set, enabled
// - Port A input enable untouched, feeds memory data
// - address_phase_active marks address on Port A
// - Port B7 carries timer0 A, timer1 C, change 7
// - Port B6..4 carry timer compares or changes
// - B3 program out/MISO, B2 program in/MOSI
// - B1 SPI clock, B0 SPI slave select
// - Without pull override, pull-up when dir/latch/pud 010
// - Value override replaces latch while driver on
`timescale 1ns/100ps
`include "pinmux_defines.svh"
module port_ab_mux
  import pinmux_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // APB slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // System state
  input  wire logic       sleep_mode,
  // External memory interface
  input  wire logic       address_phase_active,
  input  wire logic       store_strobe_active,
  input  wire port_byte_t mem_addr_low,
  input  wire port_byte_t mem_data_out,
  output port_byte_t      mem_data_in,
  // Timer compare outputs
  input  wire logic       timer0_compare_a_en,
  input  wire logic       timer0_compare_a_out,
  input  wire logic       timer1_compare_c_en,
  input  wire logic       timer1_compare_c_out,
  input  wire logic       timer1_compare_b_en,
  input  wire logic       timer1_compare_b_out,
  input  wire logic       timer1_compare_a_en,
  input  wire logic       timer1_compare_a_out,
  input  wire logic       timer2_compare_a_en,
  input  wire logic       timer2_compare_a_out,
  // SPI and serial programming
  input  wire logic       spi_enable,
  input  wire logic       spi_master,
  input  wire logic       spi_slave_out,
  input  wire logic       spi_master_out,
  input  wire logic       spi_sck_out,
  input  wire logic       prog_mode,
  input  wire logic       program_data_out,
  output logic            spi_miso_in,
  output logic            spi_mosi_in,
  output logic            spi_sck_in,
  output logic            spi_ss_in,
  output logic            program_data_in,
  // Pin change
  input  wire port_byte_t pin_change_enable,
  output port_byte_t      pin_change_source,
  // Control outputs
  output logic            debug_port_disable,
  output logic            vector_table_select,
  output logic            vector_change_enable,
  // Pads
  input  wire port_byte_t pa_in,
  output port_byte_t      pa_out,
  output port_byte_t      pa_oe,
  output port_byte_t      pa_pullup,
  input  wire port_byte_t pb_in,
  output port_byte_t      pb_out,
  output port_byte_t      pb_oe,
  output port_byte_t      pb_pullup
);

  // ==========================================
  // Registers
  port_byte_t mcu_control_r;
  port_byte_t pa_dir_r;
  port_byte_t pa_latch_r;
  port_byte_t pb_dir_r;
  port_byte_t pb_latch_r;
  logic       ext_mem_enable_r;
  port_byte_t pa_sync;
  port_byte_t pb_sync;
  port_byte_t pa_din;
  port_byte_t pb_din;
  port_byte_t pb_in_en;
  logic       pull_up_disable;
  logic       wr_en;
  logic       setup;

  assign pull_up_disable   = mcu_control_r[`MCU_PUD];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `OFS_MCU_CONTROL, `OFS_PA_DIR, `OFS_PA_LATCH, `OFS_PA_PIN,
      `OFS_PB_DIR, `OFS_PB_LATCH, `OFS_PB_PIN, `OFS_EMI_CTRL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // Generic pad resolution shared by both ports
  function automatic pad_ctl_t pad_resolve(
    input logic dir, input logic latch, input logic pu_dis,
    input logic pullup_override_en, input logic pullup_override_val,
    input logic dir_override_en, input logic dir_override_val,
    input logic value_override_en, input logic value_override_val);
    pad_ctl_t p;
    p.oe  = dir_override_en ? dir_override_val : dir;
    p.out = (value_override_en && p.oe) ? value_override_val : latch;
    p.pu  = pullup_override_en ? pullup_override_val : (!dir && latch && !pu_dis);
    pad_resolve = p;
  endfunction

  // ==========================================
  // Pad synchronisers
  pin_sync u_sync_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .pad_in   (pa_in),
    .sync_out (pa_sync)
  );

  pin_sync u_sync_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .pad_in   (pb_in),
    .sync_out (pb_sync)
  );

  // ==========================================
  // APB register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_control_r <= `MCU_RESET;
    end else if (wr_en && paddr == `OFS_MCU_CONTROL) begin
      mcu_control_r <= pwdata[7:0] & `MCU_WR_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_dir_r   <= `PORT_RESET;
      pa_latch_r <= `PORT_RESET;
      pb_dir_r   <= `PORT_RESET;
      pb_latch_r <= `PORT_RESET;
    end else if (wr_en) begin
      case (paddr)
        `OFS_PA_DIR:   pa_dir_r   <= pwdata[7:0];
        `OFS_PA_LATCH: pa_latch_r <= pwdata[7:0];
        `OFS_PB_DIR:   pb_dir_r   <= pwdata[7:0];
        `OFS_PB_LATCH: pb_latch_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mem_enable_r <= 1'b0;
    end else if (wr_en && paddr == `OFS_EMI_CTRL) begin
      ext_mem_enable_r <= pwdata[`EMI_ENABLE_BIT];
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= !addr_ok(paddr);
        prdata  <= 32'h0000_0000;
        if (!pwrite) begin
          case (paddr)
            `OFS_MCU_CONTROL: prdata[7:0] <= mcu_control_r;
            `OFS_PA_DIR:      prdata[7:0] <= pa_dir_r;
            `OFS_PA_LATCH:    prdata[7:0] <= pa_latch_r;
            `OFS_PA_PIN:      prdata[7:0] <= pa_din;
            `OFS_PB_DIR:      prdata[7:0] <= pb_dir_r;
            `OFS_PB_LATCH:    prdata[7:0] <= pb_latch_r;
            `OFS_PB_PIN:      prdata[7:0] <= pb_din;
            `OFS_EMI_CTRL:    prdata[`EMI_ENABLE_BIT] <= ext_mem_enable_r;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_port_disable   <= 1'b0;
      vector_table_select  <= 1'b0;
      vector_change_enable <= 1'b0;
    end else begin
      debug_port_disable   <= mcu_control_r[`MCU_DEBUG_DIS];
      vector_table_select  <= mcu_control_r[`MCU_VEC_SEL];
      vector_change_enable <= mcu_control_r[`MCU_VEC_CHG];
    end
  end

  // ==========================================
  // Port A: external memory address/data lines
  // Combinational so the bus turns round in the phase's own cycle
  always_comb begin
    pad_ctl_t p;
    logic     busy;
    p    = '0;
    busy = store_strobe_active || address_phase_active;
    for (int n = 0; n < 8; n++) begin
      p = pad_resolve(pa_dir_r[n], pa_latch_r[n], pull_up_disable,
                      ext_mem_enable_r,
                      !busy && pa_latch_r[n] && !pull_up_disable,
                      ext_mem_enable_r, busy,
                      ext_mem_enable_r,
                      (mem_addr_low[n] && address_phase_active) ||
                      (mem_data_out[n] && store_strobe_active));
      pa_oe[n]     = p.oe;
      pa_out[n]    = p.out;
      pa_pullup[n] = p.pu;
    end
  end

  // Input enable follows sleep only; memory never overrides it
  assign pa_din = pa_sync & {8{!sleep_mode}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_data_in <= `PORT_RESET;
    end else begin
      mem_data_in <= pa_din;
    end
  end

  // ==========================================
  // Port B: timers, SPI, programming, pin change
  logic spi_mst;
  logic spi_slv;
  assign spi_mst = spi_enable && spi_master;
  assign spi_slv = spi_enable && !spi_master;

  always_comb begin
    pad_ctl_t p;
    p = '0;
    // B7: compare output only reaches the pad once software sets its direction
    p = pad_resolve(pb_dir_r[`PIN_B7], pb_latch_r[`PIN_B7], pull_up_disable, 1'b0, 1'b0, 1'b0, 1'b0,
                    timer0_compare_a_en || timer1_compare_c_en,
                    (timer0_compare_a_en && timer0_compare_a_out) ||
                    (timer1_compare_c_en && timer1_compare_c_out));
    {pb_oe[7], pb_out[7], pb_pullup[7]} = p;
    p = pad_resolve(pb_dir_r[6], pb_latch_r[6], pull_up_disable, 1'b0, 1'b0, 1'b0, 1'b0,
                    timer1_compare_b_en, timer1_compare_b_out);
    {pb_oe[6], pb_out[6], pb_pullup[6]} = p;
    p = pad_resolve(pb_dir_r[5], pb_latch_r[5], pull_up_disable, 1'b0, 1'b0, 1'b0, 1'b0,
                    timer1_compare_a_en, timer1_compare_a_out);
    {pb_oe[5], pb_out[5], pb_pullup[5]} = p;
    p = pad_resolve(pb_dir_r[4], pb_latch_r[4], pull_up_disable, 1'b0, 1'b0, 1'b0, 1'b0,
                    timer2_compare_a_en, timer2_compare_a_out);
    {pb_oe[4], pb_out[4], pb_pullup[4]} = p;
    // B3: programming output wins; SPI master forces input
    p = pad_resolve(pb_dir_r[`PIN_SPI_MISO], pb_latch_r[`PIN_SPI_MISO], pull_up_disable,
                    spi_mst && !prog_mode, pb_latch_r[`PIN_SPI_MISO] && !pull_up_disable,
                    prog_mode || spi_mst, prog_mode,
                    prog_mode || spi_slv,
                    prog_mode ? program_data_out : spi_slave_out);
    {pb_oe[3], pb_out[3], pb_pullup[3]} = p;
    // B2: programming input or SPI slave forces input
    p = pad_resolve(pb_dir_r[`PIN_SPI_MOSI], pb_latch_r[`PIN_SPI_MOSI], pull_up_disable,
                    spi_slv || prog_mode, pb_latch_r[`PIN_SPI_MOSI] && !pull_up_disable,
                    spi_slv || prog_mode, 1'b0,
                    spi_mst && !prog_mode, spi_master_out);
    {pb_oe[2], pb_out[2], pb_pullup[2]} = p;
    p = pad_resolve(pb_dir_r[`PIN_SPI_SCK], pb_latch_r[`PIN_SPI_SCK], pull_up_disable,
                    spi_slv, pb_latch_r[`PIN_SPI_SCK] && !pull_up_disable,
                    spi_slv, 1'b0, spi_mst, spi_sck_out);
    {pb_oe[1], pb_out[1], pb_pullup[1]} = p;
    p = pad_resolve(pb_dir_r[`PIN_SPI_SS], pb_latch_r[`PIN_SPI_SS], pull_up_disable,
                    spi_slv, pb_latch_r[`PIN_SPI_SS] && !pull_up_disable,
                    spi_slv, 1'b0, 1'b0, 1'b0);
    {pb_oe[0], pb_out[0], pb_pullup[0]} = p;
  end

  // Enabled change sources keep their input alive through sleep
  assign pb_in_en = pin_change_enable | {8{!sleep_mode}};
  assign pb_din   = pb_sync & pb_in_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_source <= `PORT_RESET;
      spi_miso_in       <= 1'b0;
      spi_mosi_in       <= 1'b0;
      spi_sck_in        <= 1'b0;
      spi_ss_in         <= 1'b1;
      program_data_in   <= 1'b0;
    end else begin
      pin_change_source <= pb_din & pin_change_enable;
      spi_miso_in       <= pb_din[`PIN_SPI_MISO];
      spi_mosi_in       <= pb_din[`PIN_SPI_MOSI];
      spi_sck_in        <= pb_din[`PIN_SPI_SCK];
      spi_ss_in         <= pb_din[`PIN_SPI_SS];
      program_data_in   <= pb_din[`PIN_SPI_MOSI];
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pud_off;
    pull_up_disable |-> (pa_pullup == 8'h00) && (pb_pullup == 8'h00);
  endproperty
  a_pud_off: assert property (p_pud_off)
    else $error("pull-up active while disabled");

  property p_mcu_write;
    wr_en && paddr == `OFS_MCU_CONTROL |=> mcu_control_r == ($past(pwdata[7:0]) & `MCU_WR_MASK);
  endproperty
  a_mcu_write: assert property (p_mcu_write)
    else $error("mcu_control write wrong");

  property p_normal_a;
    !ext_mem_enable_r |-> pa_oe == pa_dir_r && (pa_out & pa_oe) == (pa_latch_r & pa_oe);
  endproperty
  a_normal_a: assert property (p_normal_a)
    else $error("Port A not following its registers");

  property p_emi_oe;
    ext_mem_enable_r |-> pa_oe == {8{store_strobe_active || address_phase_active}};
  endproperty
  a_emi_oe: assert property (p_emi_oe)
    else $error("Port A drive wrong under memory mode");

  property p_emi_addr;
    ext_mem_enable_r && address_phase_active && !store_strobe_active |-> pa_out == mem_addr_low;
  endproperty
  a_emi_addr: assert property (p_emi_addr)
    else $error("address not on Port A");

  property p_emi_pull;
    ext_mem_enable_r |->
      pa_pullup == (pa_latch_r & {8{!(store_strobe_active || address_phase_active) && !pull_up_disable}});
  endproperty
  a_emi_pull: assert property (p_emi_pull)
    else $error("Port A pull-up wrong under memory mode");

  property p_mem_in;
    // Pipeline holds reset values for the first edges after release
    $past(presetn, 2) && $past(presetn) && !sleep_mode ##1 !sleep_mode |-> mem_data_in == $past(pa_in, 3);
  endproperty
  a_mem_in: assert property (p_mem_in)
    else $error("memory data input not from Port A");

  property p_b7_timer0;
    timer0_compare_a_en && !timer1_compare_c_en && pb_dir_r[7] |->
      pb_oe[7] && pb_out[7] == timer0_compare_a_out;
  endproperty
  a_b7_timer0: assert property (p_b7_timer0)
    else $error("B7 not carrying timer0 compare");

  property p_b_pull;
    !spi_enable && !prog_mode |-> pb_pullup == (~pb_dir_r & pb_latch_r & {8{!pull_up_disable}});
  endproperty
  a_b_pull: assert property (p_b_pull)
    else $error("Port B default pull-up wrong");

  property p_b_sck;
    spi_mst && pb_dir_r[1] |-> pb_out[1] == spi_sck_out;
  endproperty
  a_b_sck: assert property (p_b_sck)
    else $error("SPI clock not on B1");

endmodule // port_ab_mux

/* tb/ext_mem_model.sv */
// External memory model on the multiplexed Port A address/data lines
`timescale 1ns/100ps
module ext_mem_model
  import pinmux_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bus phases
  input  wire logic       address_phase_active,
  input  wire logic       store_strobe_active,
  input  wire logic       mem_read,
  // Pads
  input  wire port_byte_t pa_out,
  input  wire port_byte_t pa_oe,
  input  wire port_byte_t pa_pullup,
  output port_byte_t      pa_in
);
  port_byte_t mem [256];
  port_byte_t addr_r;
  port_byte_t last_r;
  port_byte_t far_v;

  // ==========================================
  // Pad level
  // Undriven lines toggle unless pulled up or being read, so a stale value never passes for data
  always_comb begin
    far_v = mem_read ? mem[addr_r] : ~last_r;
    for (int i = 0; i < 8; i++) begin
      pa_in[i] = pa_oe[i] ? pa_out[i] : ((pa_pullup[i] && !mem_read) ? 1'b1 : far_v[i]);
    end
  end

  // ==========================================
  // Address latch and storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 8'h00;
      last_r <= 8'h00;
    end else begin
      last_r <= pa_in;
      if (address_phase_active) begin
        addr_r <= pa_in;
      end
      if (store_strobe_active) begin
        mem[addr_r] <= pa_in;
      end
    end
  end
endmodule // ext_mem_model

/* tb/port_ab_mux_tb.sv */
// Register, pad override and alternate function tests of the port multiplexer
`timescale 1ns/100ps
`include "pinmux_defines.svh"
module port_ab_mux_tb
  import pinmux_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        address_phase_active, store_strobe_active, mem_read;
  port_byte_t  mem_addr_low, mem_data_out, mem_data_in, pin_change_enable, pin_change_source;
  logic [4:0]  tmr_en, tmr_out;
  logic        spi_enable, spi_master, spi_slave_out, spi_master_out, spi_sck_out, prog_mode, program_data_out;
  logic        spi_miso_in, spi_mosi_in, spi_sck_in, spi_ss_in, program_data_in;
  logic        debug_port_disable, vector_table_select, vector_change_enable;
  port_byte_t  pa_in, pa_out, pa_oe, pa_pullup, pb_in, pb_out, pb_oe, pb_pullup;
  int          n_fail, cmp_count;

  port_ab_mux u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_mode,
    .address_phase_active, .store_strobe_active, .mem_addr_low, .mem_data_out, .mem_data_in,
    .timer0_compare_a_en(tmr_en[0]), .timer0_compare_a_out(tmr_out[0]),
    .timer1_compare_c_en(tmr_en[1]), .timer1_compare_c_out(tmr_out[1]),
    .timer1_compare_b_en(tmr_en[2]), .timer1_compare_b_out(tmr_out[2]),
    .timer1_compare_a_en(tmr_en[3]), .timer1_compare_a_out(tmr_out[3]),
    .timer2_compare_a_en(tmr_en[4]), .timer2_compare_a_out(tmr_out[4]),
    .spi_enable, .spi_master, .spi_slave_out, .spi_master_out, .spi_sck_out, .prog_mode, .program_data_out,
    .spi_miso_in, .spi_mosi_in, .spi_sck_in, .spi_ss_in, .program_data_in, .pin_change_enable,
    .pin_change_source, .debug_port_disable, .vector_table_select, .vector_change_enable,
    .pa_in, .pa_out, .pa_oe, .pa_pullup, .pb_in, .pb_out, .pb_oe, .pb_pullup
  );

  ext_mem_model u_mem (
    .pclk, .presetn, .address_phase_active, .store_strobe_active, .mem_read, .pa_out, .pa_oe, .pa_pullup, .pa_in
  );

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Request held until pready is seen high at an access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      conclude();
    end
  endtask

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic apb_rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_e);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r[7:0], exp);
    chk(8'(|r[31:8]), 8'h00);
    chk(8'(e), 8'(exp_e));
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    sleep_mode = 1'b0; address_phase_active = 1'b0; store_strobe_active = 1'b0; mem_read = 1'b0;
    mem_addr_low = 8'h00; mem_data_out = 8'h00; tmr_en = 5'h00; tmr_out = 5'h00;
    spi_enable = 1'b0; spi_master = 1'b0; spi_slave_out = 1'b0; spi_master_out = 1'b0; spi_sck_out = 1'b0;
    prog_mode = 1'b0; program_data_out = 1'b0; pin_change_enable = 8'h00; pb_in = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb_rd(`OFS_MCU_CONTROL, 8'h00, 1'b0);
    apb_wr(`OFS_MCU_CONTROL, 32'hFF);
    apb_rd(`OFS_MCU_CONTROL, 8'h93, 1'b0);
    chk(8'({debug_port_disable, vector_table_select, vector_change_enable}), 8'h07);
    apb_rd(8'h20, 8'h00, 1'b1);
    // Ordinary port control
    apb_wr(`OFS_MCU_CONTROL, 32'h00);
    apb_wr(`OFS_PA_DIR, 32'h0F);
    apb_wr(`OFS_PA_LATCH, 32'h5A);
    settle(1);
    chk(pa_oe, 8'h0F);
    chk(pa_out & 8'h0F, 8'h0A);
    chk(pa_pullup, 8'h50);
    apb_wr(`OFS_MCU_CONTROL, 32'h10);
    settle(1);
    chk(pa_pullup, 8'h00);
    // Memory interface override
    apb_wr(`OFS_MCU_CONTROL, 32'h00);
    apb_wr(`OFS_EMI_CTRL, 32'h01);
    settle(1);
    chk(pa_oe, 8'h00);
    chk(pa_pullup, 8'h5A);
    @(posedge pclk);
    address_phase_active <= 1'b1;
    mem_addr_low <= 8'h3C;
    mem_data_out <= 8'hC3;
    #1;
    chk(pa_oe, 8'hFF);
    chk(pa_out, 8'h3C);
    chk(pa_pullup, 8'h00);
    @(posedge pclk);
    address_phase_active <= 1'b0;
    store_strobe_active <= 1'b1;
    #1;
    chk(pa_out, 8'hC3);
    chk(pa_oe, 8'hFF);
    @(posedge pclk);
    store_strobe_active <= 1'b0;
    address_phase_active <= 1'b1;
    @(posedge pclk);
    address_phase_active <= 1'b0;
    mem_read <= 1'b1;
    settle(5);
    chk(pa_oe, 8'h00);
    chk(mem_data_in, 8'hC3);
    apb_rd(`OFS_PA_PIN, 8'hC3, 1'b0);
    apb_rd(`OFS_EMI_CTRL, 8'h01, 1'b0);
    @(posedge pclk);
    mem_read <= 1'b0;
    apb_wr(`OFS_MCU_CONTROL, 32'h10);
    settle(1);
    chk(pa_pullup, 8'h00);
    apb_wr(`OFS_EMI_CTRL, 32'h00);
    apb_wr(`OFS_MCU_CONTROL, 32'h00);
    // Timer compare outputs on Port B
    apb_wr(`OFS_PB_DIR, 32'hFF);
    tmr_out <= 5'h1F;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      tmr_en <= 5'(1 << i);
      #1;
      chk(pb_out, (i < 2) ? 8'h80 : 8'(8'h80 >> (i - 1)));
    end
    apb_wr(`OFS_PB_DIR, 32'h00);
    settle(1);
    chk(pb_oe, 8'h00);
    apb_wr(`OFS_PB_LATCH, 32'hFF);
    settle(1);
    chk(pb_pullup, 8'hFF);
    apb_wr(`OFS_MCU_CONTROL, 32'h10);
    settle(1);
    chk(pb_pullup, 8'h00);
    apb_wr(`OFS_MCU_CONTROL, 32'h00);
    apb_wr(`OFS_PB_LATCH, 32'h00);
    // Pin change sources, kept alive through sleep
    @(posedge pclk);
    tmr_en <= 5'h00;
    pin_change_enable <= 8'hA5;
    pb_in <= 8'hFF;
    sleep_mode <= 1'b1;
    settle(4);
    chk(pin_change_source, 8'hA5);
    apb_rd(`OFS_PB_PIN, 8'hA5, 1'b0);
    sleep_mode <= 1'b0;
    // SPI master, slave and serial programming
    apb_wr(`OFS_PB_DIR, 32'hFF);
    spi_enable <= 1'b1;
    spi_master <= 1'b1;
    spi_master_out <= 1'b1;
    spi_sck_out <= 1'b1;
    pb_in <= 8'h08;
    settle(4);
    chk(pb_oe, 8'hF7);
    chk(pb_out, 8'h06);
    chk(8'(spi_miso_in), 8'h01);
    @(posedge pclk);
    spi_master <= 1'b0;
    spi_slave_out <= 1'b1;
    pb_in <= 8'h06;
    settle(4);
    chk(pb_oe, 8'hF8);
    chk(pb_out, 8'h08);
    chk(8'({spi_mosi_in, spi_sck_in, spi_ss_in}), 8'h06);
    @(posedge pclk);
    prog_mode <= 1'b1;
    program_data_out <= 1'b1;
    spi_slave_out <= 1'b0;
    pb_in <= 8'h04;
    settle(4);
    chk(pb_out, 8'h08);
    chk(pb_oe & 8'h0C, 8'h08);
    chk(8'(program_data_in), 8'h01);
    conclude();
  end
endmodule // port_ab_mux_tb
